// ===== shared/lcd_pin_mux_pkg.sv
// Constants and types shared by the panel pin multiplexer and its bench.
package lcd_pin_mux_pkg;
    localparam int PANEL_DATA_W   = 18;
    localparam int MODE_W         = 2;
    localparam int INT_SRC_W      = 4;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int PCLK_DIV_DEF   = 4;

    // Panel mode field, bits 1-0: values 0..3 stand for modes 1..4.
    localparam int MODE_FIELD_LSB            = 0;
    localparam logic [MODE_W-1:0] MODE_RGB_SER = 2'h0;
    localparam logic [MODE_W-1:0] MODE_PAR_SER = 2'h1;
    localparam logic [MODE_W-1:0] MODE_PAR_PAR = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RGB_PAR = 2'h3;
    localparam logic [MODE_W-1:0] MODE_RST     = 2'h0;

    // Tri-state control bit position in its two configuration words.
    localparam int TRI_CTL_BIT = 13;

    // Inactive levels shown on every pin while reset is applied.
    localparam logic                    PIN_RST  = 1'b0;
    localparam logic                    CS_N_RST = 1'b1;
    localparam logic                    OE_RST   = 1'b0;
    localparam logic [PANEL_DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [INT_SRC_W-1:0]    INT_RST  = 4'h0;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_RGB,
        SRC_PAR,
        SRC_HOST
    } pin_src_t;

    typedef enum logic [1:0] {
        SER_OFF,
        SER_ENGINE,
        SER_HOST
    } ser_src_t;
endpackage

// ===== design/stream_fifo.sv
// Synchronous FIFO with valid/ready handshakes on both sides.
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Full compares the wrap bits, so all DEPTH slots are usable.
    assign empty     = (wr_ptr_q == rd_ptr_q);
    assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                       (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== design/lcd_panel_pin_mux_bypass.sv
// Panel pin multiplexer with host bypass, interrupt pin and pixel FIFO.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - Interrupt pin goes high on any event.
// R2 - Host clears event, interrupt pin returns low.
// R3 - Reset forces defaults and inactive pin levels.
// R4 - Serial bypass takes host serial select inputs.
// R5 - Mode field selects the panel interface pair.
// R6 - Modes 1 and 4 put RGB data out.
// R7 - Parallel modes reuse data bus for writes.
// R8 - Either tri-state bit makes data bus tri-state outside writes, except in RGB modes.
// R9 - Parallel bypass passes host data to bus.
// R10 - RGB modes drive frame pin as frame pulse.
// R11 - Parallel modes drive frame pin as write strobe.
// R12 - Parallel bypass drives frame pin from host strobe.
// R13 - RGB modes drive line pin as line pulse.
// R14 - Parallel modes drive line pin as command select.
// R15 - Parallel bypass drives line pin from host select.
// R16 - Pixel clock only in RGB modes, else idle.
// R17 - Parallel bypass drives first panel chip select.
// R18 - Serial bypass drives panel serial clock.
// R19 - Serial bypass drives panel serial data.
// R20 - Selection registered; bypass outranks the mode field.
module lcd_panel_pin_mux_bypass
    import lcd_pin_mux_pkg::*;
#(
    parameter int DATA_W     = PANEL_DATA_W,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int PCLK_DIV   = PCLK_DIV_DEF,
    parameter int INT_W      = INT_SRC_W
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic [MODE_W-1:0] panel_mode,
    input  wire logic              parallel_bypass,
    input  wire logic              serial_bypass,
    input  wire logic              tri_ctl_a,
    input  wire logic              tri_ctl_b,
    input  wire logic [INT_W-1:0]  int_event,
    input  wire logic [INT_W-1:0]  int_clear,
    input  wire logic [DATA_W-1:0] pixel_data,
    input  wire logic              pixel_valid,
    output logic                   pixel_ready,
    input  wire logic              rgb_frame,
    input  wire logic              rgb_line,
    input  wire logic              par_active,
    input  wire logic              par_write_cmd,
    input  wire logic              par_cmd_select,
    input  wire logic              par_chip_select_n,
    input  wire logic              eng_chip_select_n,
    input  wire logic              eng_serial_select_n,
    input  wire logic              eng_serial_clock,
    input  wire logic              eng_serial_cmd,
    input  wire logic              eng_serial_data,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic              host_write_strobe,
    input  wire logic              host_cmd_select,
    input  wire logic              host_chip_select_one_n,
    input  wire logic              host_serial_chip_select_n,
    input  wire logic              host_serial_clock,
    input  wire logic              host_serial_cmd_select,
    input  wire logic              host_serial_data,
    output logic [DATA_W-1:0]      panel_data_bus,
    output logic                   panel_data_oe,
    output logic                   panel_frame_pulse,
    output logic                   panel_line_pulse,
    output logic                   panel_pixel_clock,
    output logic                   panel_one_chip_select_n,
    output logic                   panel_two_chip_select_n,
    output logic                   panel_serial_clock,
    output logic                   panel_serial_cmd,
    output logic                   panel_serial_data_out,
    output logic                   interrupt_out
);
    localparam int DIV_W = $clog2(PCLK_DIV) + 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PCLK_DIV - 1);

    logic [1:0]        rst_sync_q;
    logic              rst_sync_n;
    pin_src_t          src_q;
    ser_src_t          ser_src_q;
    logic [INT_W-1:0]  int_pend_q;
    logic [DIV_W-1:0]  div_q;
    logic              pix_tick;
    logic              pclk_q;
    logic [DATA_W-1:0] stream_q;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic              streaming;
    logic              drive_window;

    // Bypass is checked first so the host always wins over the mode field.
    function automatic pin_src_t pick_src(input logic [MODE_W-1:0] mode,
                                          input logic pbyp,
                                          input logic par_on);
        pin_src_t s;
        s = SRC_NONE;
        if (pbyp) begin
            s = SRC_HOST;
        end else begin
            case (mode)
                MODE_RGB_SER: s = SRC_RGB;
                MODE_PAR_SER: s = SRC_PAR;
                MODE_PAR_PAR: s = SRC_PAR;
                MODE_RGB_PAR: s = par_on ? SRC_PAR : SRC_RGB;
                default:      s = SRC_NONE;
            endcase
        end
        return s;
    endfunction

    function automatic ser_src_t pick_ser(input logic [MODE_W-1:0] mode,
                                          input logic sbyp);
        ser_src_t s;
        s = SER_OFF;
        if (sbyp) begin
            s = SER_HOST;
        end else if (mode != MODE_PAR_PAR) begin
            s = SER_ENGINE;
        end
        return s;
    endfunction

    // Reset is applied at once but released only after two clean edges.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    // Registering the choice keeps decode glitches off the panel pins.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_q     <= SRC_NONE; // [R3]
            ser_src_q <= SER_OFF;
        end else begin
            src_q     <= pick_src(panel_mode, parallel_bypass, par_active); // [R5] [R20]
            ser_src_q <= pick_ser(panel_mode, serial_bypass); // [R20]
        end
    end

    // A pending bit is set by its event and dropped by the host clear;
    // a new event in the clearing cycle is kept.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_pend_q <= INT_RST; // [R3]
        end else begin
            int_pend_q <= (int_pend_q & ~int_clear) | int_event; // [R2]
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            interrupt_out <= PIN_RST;
        end else begin
            interrupt_out <= |int_pend_q; // [R1] [R2]
        end
    end

    // Pixel clock divider: one tick enable every PCLK_DIV cycles.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_q <= '0;
        end else if (div_q == DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign pix_tick = (div_q == DIV_LAST);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pclk_q <= PIN_RST;
        end else if (!streaming) begin
            pclk_q <= PIN_RST;
        end else if (pix_tick) begin
            pclk_q <= !pclk_q;
        end
    end

    // The stream only drains at the pixel rate, so a faster source fills the
    // FIFO and is held off by pixel_ready.
    assign streaming = (src_q == SRC_RGB) || (src_q == SRC_PAR);
    assign fifo_pop  = streaming && pix_tick && pclk_q;

    stream_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst_n     (rst_sync_n),
        .in_data   (pixel_data),
        .in_valid  (pixel_valid),
        .in_ready  (pixel_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stream_q <= DATA_RST;
        end else if (fifo_pop && fifo_valid) begin
            stream_q <= fifo_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_data_bus <= DATA_RST; // [R3]
        end else begin
            case (src_q)
                SRC_RGB:  panel_data_bus <= stream_q; // [R6]
                SRC_PAR:  panel_data_bus <= stream_q; // [R7]
                SRC_HOST: panel_data_bus <= host_data; // [R9]
                default:  panel_data_bus <= DATA_RST;
            endcase
        end
    end

    // With tri-state control the bus is always driven in RGB modes, otherwise only while a write is on.
    assign drive_window = (src_q == SRC_RGB) ||
                          (src_q == SRC_PAR && par_write_cmd) ||
                          (src_q == SRC_HOST && host_write_strobe);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_data_oe <= OE_RST;
        end else if (tri_ctl_a || tri_ctl_b) begin
            panel_data_oe <= drive_window; // [R8]
        end else begin
            panel_data_oe <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_frame_pulse <= PIN_RST;
        end else begin
            case (src_q)
                SRC_RGB:  panel_frame_pulse <= rgb_frame; // [R10]
                SRC_PAR:  panel_frame_pulse <= par_write_cmd; // [R11]
                SRC_HOST: panel_frame_pulse <= host_write_strobe; // [R12]
                default:  panel_frame_pulse <= PIN_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_line_pulse <= PIN_RST;
        end else begin
            case (src_q)
                SRC_RGB:  panel_line_pulse <= rgb_line; // [R13]
                SRC_PAR:  panel_line_pulse <= par_cmd_select; // [R14]
                SRC_HOST: panel_line_pulse <= host_cmd_select; // [R15]
                default:  panel_line_pulse <= PIN_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_pixel_clock <= PIN_RST;
        end else begin
            panel_pixel_clock <= (src_q == SRC_RGB) && pclk_q; // [R16]
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_one_chip_select_n <= CS_N_RST;
        end else begin
            case (src_q)
                SRC_HOST: panel_one_chip_select_n <= host_chip_select_one_n; // [R17]
                SRC_PAR:  panel_one_chip_select_n <= par_chip_select_n;
                SRC_RGB:  panel_one_chip_select_n <= eng_chip_select_n;
                default:  panel_one_chip_select_n <= CS_N_RST;
            endcase
        end
    end

    // The serial pins follow their own selection so both bypasses may coexist.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_two_chip_select_n <= CS_N_RST;
            panel_serial_clock      <= PIN_RST;
            panel_serial_cmd        <= PIN_RST;
            panel_serial_data_out   <= PIN_RST;
        end else begin
            case (ser_src_q)
                SER_HOST: begin
                    panel_two_chip_select_n <= host_serial_chip_select_n; // [R4]
                    panel_serial_clock      <= host_serial_clock; // [R18]
                    panel_serial_cmd        <= host_serial_cmd_select; // [R4]
                    panel_serial_data_out   <= host_serial_data; // [R19]
                end
                SER_ENGINE: begin
                    panel_two_chip_select_n <= eng_serial_select_n;
                    panel_serial_clock      <= eng_serial_clock;
                    panel_serial_cmd        <= eng_serial_cmd;
                    panel_serial_data_out   <= eng_serial_data;
                end
                default: begin
                    panel_two_chip_select_n <= CS_N_RST;
                    panel_serial_clock      <= PIN_RST;
                    panel_serial_cmd        <= PIN_RST;
                    panel_serial_data_out   <= PIN_RST;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    a_irq_raise: assert property (int_event != '0 |-> ##2 interrupt_out) // [R1]
        else $error("interrupt pin did not rise after an event");
    a_irq_fall: assert property ((int_pend_q & ~int_clear) == '0 && int_event == '0
                                 |-> ##2 !interrupt_out) // [R2]
        else $error("interrupt pin stayed high after clear");
    a_reset_idle: assert property ($rose(rst_sync_n) |-> panel_one_chip_select_n &&
                                   !panel_data_oe && !panel_frame_pulse && !interrupt_out) // [R3]
        else $error("pins not inactive at reset release");
    a_mode_decode: assert property (!parallel_bypass && panel_mode == MODE_PAR_PAR
                                    |=> src_q == SRC_PAR) // [R5]
        else $error("mode field not decoded to parallel");
    a_bypass_wins: assert property (parallel_bypass |=> src_q == SRC_HOST) // [R20]
        else $error("parallel bypass did not take priority");
    a_serial_wins: assert property (serial_bypass |=> ser_src_q == SER_HOST) // [R20]
        else $error("serial bypass did not take priority");
    a_rgb_data: assert property (src_q == SRC_RGB |=> panel_data_bus == $past(stream_q)) // [R6]
        else $error("rgb data not on panel bus");
    a_par_data: assert property (src_q == SRC_PAR |=> panel_data_bus == $past(stream_q)) // [R7]
        else $error("parallel data not on panel bus");
    a_tri_off: assert property (!tri_ctl_a && !tri_ctl_b |=> panel_data_oe) // [R8]
        else $error("bus released without tri-state control");
    a_tri_on: assert property ((tri_ctl_a || tri_ctl_b) && !drive_window |=> !panel_data_oe) // [R8]
        else $error("bus driven outside write under tri-state");
    a_host_data: assert property (parallel_bypass ##1 parallel_bypass
                                  |=> panel_data_bus == $past(host_data)) // [R9]
        else $error("host data not passed through");
    a_frame_rgb: assert property (src_q == SRC_RGB |=> panel_frame_pulse == $past(rgb_frame)) // [R10]
        else $error("frame pin not frame pulse");
    a_frame_par: assert property (src_q == SRC_PAR
                                  |=> panel_frame_pulse == $past(par_write_cmd)) // [R11]
        else $error("frame pin not write strobe");
    a_frame_host: assert property (parallel_bypass ##1 parallel_bypass
                                   |=> panel_frame_pulse == $past(host_write_strobe)) // [R12]
        else $error("frame pin not host write strobe");
    a_line_rgb: assert property (src_q == SRC_RGB |=> panel_line_pulse == $past(rgb_line)) // [R13]
        else $error("line pin not line pulse");
    a_line_par: assert property (src_q == SRC_PAR
                                 |=> panel_line_pulse == $past(par_cmd_select)) // [R14]
        else $error("line pin not command select");
    a_line_host: assert property (parallel_bypass ##1 parallel_bypass
                                  |=> panel_line_pulse == $past(host_cmd_select)) // [R15]
        else $error("line pin not host command select");
    a_pclk_idle: assert property (src_q != SRC_RGB |=> !panel_pixel_clock) // [R16]
        else $error("pixel clock runs outside rgb mode");
    a_cs_host: assert property (parallel_bypass ##1 parallel_bypass
                                |=> panel_one_chip_select_n == $past(host_chip_select_one_n)) // [R17]
        else $error("first panel select not from host");
    a_sclk_host: assert property (serial_bypass ##1 serial_bypass
                                  |=> panel_serial_clock == $past(host_serial_clock)) // [R18]
        else $error("serial clock not from host");
    a_sdata_host: assert property (serial_bypass ##1 serial_bypass
                                   |=> panel_serial_data_out == $past(host_serial_data)) // [R19]
        else $error("serial data not from host");
    a_ssel_host: assert property (serial_bypass ##1 serial_bypass
                                  |=> panel_two_chip_select_n == $past(host_serial_chip_select_n)) // [R4]
        else $error("serial select not from host");

    c_fifo_full: cover property (pixel_valid && !pixel_ready);
    c_mode4_switch: cover property (src_q == SRC_RGB ##1 src_q == SRC_PAR);
    c_irq_cycle: cover property (interrupt_out ##[1:20] !interrupt_out);
    c_both_bypass: cover property (src_q == SRC_HOST && ser_src_q == SER_HOST);
endmodule
`default_nettype wire

// ===== tb/host_serial_model.sv
// Behavioural host serial port that drives the serial bypass inputs.
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
    input  wire logic       mclk,
    input  wire logic       active,
    input  wire logic [3:0] pat,
    output logic            ser_cs_n,
    output logic            ser_clk,
    output logic            ser_cmd,
    output logic            ser_data
);
    logic [3:0] idle_q = 4'h0;
    // Idle lines wander every cycle, so a stale value never passes for a real drive.
    always @(negedge mclk) begin
        idle_q <= idle_q + 4'h1;
    end
    assign {ser_cs_n, ser_clk, ser_cmd, ser_data} = active ? pat : idle_q;
endmodule
`default_nettype wire

// ===== tb/lcd_panel_pin_mux_bypass_bench.sv
// Self-checking bench for the panel pin multiplexer.
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_pin_mux_bypass_bench;
    import lcd_pin_mux_pkg::*;
    logic        mclk, rstn, parallel_bypass, serial_bypass, tri_ctl_a, tri_ctl_b, pixel_valid, pixel_ready;
    logic        rgb_frame, rgb_line, par_active, par_write_cmd, par_cmd_select, par_chip_select_n;
    logic        eng_chip_select_n, eng_serial_select_n, eng_serial_clock, eng_serial_cmd, eng_serial_data;
    logic        host_write_strobe, host_cmd_select, host_chip_select_one_n, host_serial_chip_select_n;
    logic        host_serial_clock, host_serial_cmd_select, host_serial_data, panel_data_oe, panel_frame_pulse;
    logic        panel_line_pulse, panel_pixel_clock, panel_one_chip_select_n, panel_two_chip_select_n;
    logic        panel_serial_clock, panel_serial_cmd, panel_serial_data_out, interrupt_out, ser_on;
    logic [1:0]  panel_mode;
    logic [3:0]  int_event, int_clear, ser_pat;
    logic [17:0] pixel_data, host_data, panel_data_bus;
    int          n_fail, n_compared;

    lcd_panel_pin_mux_bypass lcd_panel_pin_mux_bypass_inst (.mclk, .rstn, .panel_mode, .parallel_bypass,
        .serial_bypass, .tri_ctl_a, .tri_ctl_b, .int_event, .int_clear, .pixel_data, .pixel_valid, .pixel_ready,
        .rgb_frame, .rgb_line, .par_active, .par_write_cmd, .par_cmd_select, .par_chip_select_n,
        .eng_chip_select_n, .eng_serial_select_n, .eng_serial_clock, .eng_serial_cmd, .eng_serial_data,
        .host_data, .host_write_strobe, .host_cmd_select, .host_chip_select_one_n, .host_serial_chip_select_n,
        .host_serial_clock, .host_serial_cmd_select, .host_serial_data, .panel_data_bus, .panel_data_oe,
        .panel_frame_pulse, .panel_line_pulse, .panel_pixel_clock, .panel_one_chip_select_n,
        .panel_two_chip_select_n, .panel_serial_clock, .panel_serial_cmd, .panel_serial_data_out, .interrupt_out);

    host_serial_model host_serial_model_inst (.mclk(mclk), .active(ser_on), .pat(ser_pat),
        .ser_cs_n(host_serial_chip_select_n), .ser_clk(host_serial_clock),
        .ser_cmd(host_serial_cmd_select), .ser_data(host_serial_data));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_interrupt();
        int_event = 4'h4;
        wait_n(1);
        int_event = 4'h0;
        wait_n(2);
        chk("irq set", 18'h00001, interrupt_out);
        int_clear = 4'h4;
        wait_n(1);
        int_clear = 4'h0;
        wait_n(2);
        chk("irq clear", 18'h00000, interrupt_out);
    endtask

    task automatic t_par_bypass();
        parallel_bypass = 1'b1;
        host_data = 18'h2a5c3;
        host_write_strobe = 1'b1;
        host_cmd_select = 1'b1;
        host_chip_select_one_n = 1'b0;
        wait_n(4);
        chk("byp data", 18'h2a5c3, panel_data_bus);
        chk("byp frame", 18'h00001, panel_frame_pulse);
        chk("byp line", 18'h00001, panel_line_pulse);
        chk("byp cs1", 18'h00000, panel_one_chip_select_n);
        parallel_bypass = 1'b0;
    endtask

    task automatic t_ser_bypass();
        serial_bypass = 1'b1;
        ser_on = 1'b1;
        ser_pat = 4'h5;
        wait_n(4);
        chk("ser clk", 18'h00001, panel_serial_clock);
        chk("ser cs2", 18'h00000, panel_two_chip_select_n);
        chk("ser data", 18'h00001, panel_serial_data_out);
        chk("ser cmd", 18'h00000, panel_serial_cmd);
        serial_bypass = 1'b0;
        ser_on = 1'b0;
    endtask

    task automatic t_parallel();
        panel_mode = MODE_PAR_SER;
        tri_ctl_a = 1'b1;
        par_write_cmd = 1'b0;
        par_cmd_select = 1'b1;
        wait_n(4);
        chk("par oe off", 18'h00000, panel_data_oe);
        chk("par cmdsel", 18'h00001, panel_line_pulse);
        chk("par nopix", 18'h00000, panel_pixel_clock);
        par_write_cmd = 1'b1;
        wait_n(3);
        chk("par strobe", 18'h00001, panel_frame_pulse);
        chk("par oe on", 18'h00001, panel_data_oe);
        tri_ctl_a = 1'b0;
        par_write_cmd = 1'b0;
        panel_mode = MODE_RGB_PAR;
        rgb_line = 1'b1;
        par_cmd_select = 1'b0;
        wait_n(4);
        chk("m4 rgb line", 18'h00001, panel_line_pulse);
        par_active = 1'b1;
        wait_n(4);
        chk("m4 par line", 18'h00000, panel_line_pulse);
        panel_mode = MODE_PAR_PAR;
        eng_serial_clock = 1'b1;
        wait_n(4);
        chk("m3 sclk idle", 18'h00000, panel_serial_clock);
        chk("m3 cs2 idle", 18'h00001, panel_two_chip_select_n);
        {rgb_line, par_active, eng_serial_clock} = 3'h0;
    endtask

    task automatic t_fifo_rgb();
        int k;
        logic pclk_seen;
        pclk_seen = 1'b0;
        parallel_bypass = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk("fifo room", 18'h00001, pixel_ready);
            pixel_data = 18'h00100 + 18'(i);
            pixel_valid = 1'b1;
            wait_n(1);
        end
        pixel_valid = 1'b0;
        chk("fifo full", 18'h00000, pixel_ready);
        panel_mode = MODE_RGB_SER;
        rgb_frame = 1'b1;
        parallel_bypass = 1'b0;
        for (int i = 0; i < 8; i++) begin
            k = 0;
            while (panel_data_bus !== 18'h00100 + 18'(i) && k < 40) begin
                pclk_seen = pclk_seen | panel_pixel_clock;
                wait_n(1);
                k++;
            end
            chk("rgb word", 18'h00100 + 18'(i), panel_data_bus);
        end
        chk("rgb frame", 18'h00001, panel_frame_pulse);
        chk("rgb line", 18'h00000, panel_line_pulse);
        chk("fifo empty", 18'h00001, pixel_ready);
        chk("rgb pclk", 18'h00001, pclk_seen);
    endtask

    initial begin
        n_fail = 0;
        n_compared = 0;
        {rstn, parallel_bypass, serial_bypass, tri_ctl_a, tri_ctl_b, pixel_valid, ser_on} = '0;
        {rgb_frame, rgb_line, par_active, par_write_cmd, par_cmd_select, host_write_strobe, host_cmd_select} = '0;
        {par_chip_select_n, eng_chip_select_n, eng_serial_select_n, host_chip_select_one_n} = 4'hf;
        {eng_serial_clock, eng_serial_cmd, eng_serial_data} = 3'h0;
        panel_mode = MODE_RGB_SER;
        {int_event, int_clear, ser_pat} = 12'h000;
        pixel_data = 18'h00000;
        host_data = 18'h00000;
        wait_n(6);
        chk("rst cs1", 18'h00001, panel_one_chip_select_n);
        chk("rst irq", 18'h00000, interrupt_out);
        rstn = 1'b1;
        wait_n(3);
        t_interrupt();
        t_par_bypass();
        t_ser_bypass();
        t_parallel();
        t_fifo_rgb();
        test_done();
    end

    initial begin
        #(50 * 5000);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
